//--- hw/link_error_recovery_handler.v
// Functional notes
// - Substate timeout declares training sequence error
// - Enhanced rate polling error goes port match
// - Base downstream polling: tally<2 detect, else inactive
// - Base upstream polling: hub detect, peripheral disabled
// - Base downstream recovery: inactive, hot reset detect
// - Base upstream recovery error goes inactive
// - Training errors touch neither error count
// - Flag disparity and undecodable symbol errors
// - Optional symbol error reaction: lbad, ignore, drop
// - Symbol errors leave link error count
// - Single-lane one-bit header error: soft count
// - Single-lane two-bit header error: recovery, link count
// - Dual-lane identical valid headers accepted, corrections counted
// - Association: one valid header accepted, its correction counted
// - Both headers invalid: report, recovery
// - Valid differing headers: report, recovery
// - No association: any invalid header recovery
// - Ignore unexpected link commands and headers
// - Downstream training request overrides upstream request
// - Missing framing: delayed recovery, link count
// - Bad header crc: retry, soft count
// - Sequence mismatch: recovery, link count
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "link_err_map.vh"

module link_error_recovery_handler #(
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Training substate events
  input wire ts_timeout,
  input wire ts_in_polling,
  input wire ts_hot_reset_attempt,
  // TS2 requested states
  input wire ts2_valid,
  input wire [2:0] ts2_local_req,
  input wire [2:0] ts2_partner_req,
  // Gen 1 symbol path
  input wire sym_valid,
  input wire [1:0] sym_disparity,
  input wire sym_known,
  input wire rx_in_header,
  input wire rx_in_lcmd,
  input wire rx_in_payload,
  // Block header path
  input wire bh_valid,
  input wire bh0_ok,
  input wire bh1_ok,
  input wire bh0_corr,
  input wire bh1_corr,
  input wire bh0_two_bit,
  input wire bh_match,
  // Header packet path
  input wire hp_framing_missing,
  input wire hp_crc_bad,
  input wire hp_seq_mismatch,
  input wire lc_unexpected,
  // Results
  output reg [2:0] next_state_reg,
  output reg next_state_stb_reg,
  output reg send_lbad_reg,
  output reg lcmd_drop_reg,
  output reg payload_drop_reg,
  output reg hp_retry_reg,
  output reg disparity_err_reg,
  output reg decode_err_reg,
  output reg bh_report_reg
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] ctrl_reg;
  reg [1:0] tally_reg;
  reg [1:0] run_disp_reg;
  reg [3:0] delay_cnt_reg;
  reg delay_busy_reg;
  reg [2:0] last_ts_state_reg;
  wire [CNT_W-1:0] link_err_cnt;
  wire [CNT_W-1:0] soft_err_cnt;

  wire enh_rate = ctrl_reg[`CTRL_ENH_RATE];
  wire downstream = ctrl_reg[`CTRL_DOWNSTREAM];
  wire is_hub = ctrl_reg[`CTRL_HUB];
  wire dual_lane = ctrl_reg[`CTRL_DUAL_LANE];
  wire assoc = ctrl_reg[`CTRL_ASSOC];
  wire sym_react = ctrl_reg[`CTRL_SYM_REACT];

  wire wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
  wire clr_counts = reg_wr && (reg_addr == `ADDR_STATUS);
  wire clr_tally = reg_wr && (reg_addr == `ADDR_TALLY);

  // ----------------------------------------
  // Training sequence error decision
  // ----------------------------------------
  reg [2:0] ts_target;
  always @*
  begin
    ts_target = `LS_NONE;
    if (enh_rate)
    begin
      if (ts_in_polling)
        ts_target = `LS_PORT_MATCH;
      else
        ts_target = `LS_INACTIVE;
    end
    else if (ts_in_polling)
    begin
      if (downstream)
        ts_target = (tally_reg < `POLL_TALLY_LIMIT) ? `LS_RX_DETECT : `LS_INACTIVE;
      else
        ts_target = is_hub ? `LS_RX_DETECT : `LS_DISABLED;
    end
    else if (downstream)
      ts_target = ts_hot_reset_attempt ? `LS_RX_DETECT : `LS_INACTIVE;
    else
      ts_target = `LS_INACTIVE;
  end

  // ----------------------------------------
  // TS2 arbitration
  // ----------------------------------------
  // Downstream request always prevails over the upstream one
  wire [2:0] ts2_win = downstream ? ts2_local_req : ts2_partner_req;

  // ----------------------------------------
  // Symbol error detection
  // ----------------------------------------
  // Running disparity held as signed two-bit code: 0, +2 (01), -2 (11)
  wire disp_bad = sym_valid && (sym_disparity == 2'b10);
  wire dec_bad = sym_valid && !sym_known;
  wire sym_err = disp_bad || dec_bad;

  // ----------------------------------------
  // Block header classification
  // ----------------------------------------
  reg bh_soft;
  reg bh_recov;
  always @*
  begin
    bh_soft = 1'b0;
    bh_recov = 1'b0;
    if (bh_valid)
    begin
      if (!dual_lane)
      begin
        bh_soft = bh0_corr && !bh0_two_bit;
        bh_recov = bh0_two_bit;
      end
      else if (bh0_ok && bh1_ok)
      begin
        if (bh_match)
          bh_soft = bh0_corr || bh1_corr;
        else
          bh_recov = 1'b1;
      end
      else if (!bh0_ok && !bh1_ok)
        bh_recov = 1'b1;
      else if (assoc)
        bh_soft = bh0_ok ? bh0_corr : bh1_corr;
      else
        bh_recov = 1'b1;
    end
  end

  // ----------------------------------------
  // Count updates
  // ----------------------------------------
  // Training and symbol errors are deliberately absent here
  wire link_inc = bh_recov || hp_seq_mismatch || hp_framing_missing;
  wire soft_inc = bh_soft || hp_crc_bad;

  err_counter #(
    .WIDTH(CNT_W)
  ) u_link_cnt (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .clear(clr_counts),
    .inc(link_inc),
    .count_reg(link_err_cnt)
  );

  err_counter #(
    .WIDTH(CNT_W)
  ) u_soft_cnt (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .clear(clr_counts),
    .inc(soft_inc),
    .count_reg(soft_err_cnt)
  );

  // ----------------------------------------
  // Control and polling tally
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_reg <= `CTRL_RESET;
      tally_reg <= 2'h0;
      run_disp_reg <= 2'h0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata;
      if (sym_valid)
        run_disp_reg <= sym_disparity;
      // Tally counts base-rate downstream polling timeouts; saturates at limit
      if (ts_timeout && ts_in_polling && downstream && !enh_rate
          && tally_reg != `POLL_TALLY_LIMIT)
        tally_reg <= tally_reg + 2'h1;
      else if (clr_tally)
        tally_reg <= 2'h0;
    end
  end

  // ----------------------------------------
  // Delayed recovery after framing loss
  // ----------------------------------------
  // Load value cut to the counter width on purpose
  wire [31:0] delay_load_full = `DELAY_RECOV_CYC - 1;
  wire [3:0] delay_load = delay_load_full[3:0];
  wire delay_done = delay_busy_reg && (delay_cnt_reg == 4'h0);

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      delay_cnt_reg <= 4'h0;
      delay_busy_reg <= 1'b0;
    end
    else if (ce)
    begin
      // Losses inside the wait are counted but do not re-arm it
      if (hp_framing_missing && !delay_busy_reg)
      begin
        delay_busy_reg <= 1'b1;
        delay_cnt_reg <= delay_load;
      end
      else if (delay_busy_reg && delay_cnt_reg != 4'h0)
        delay_cnt_reg <= delay_cnt_reg - 4'h1;
      else if (delay_done)
        delay_busy_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Next link state
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      last_ts_state_reg <= `LS_NONE;
      next_state_reg <= `LS_NONE;
      next_state_stb_reg <= 1'b0;
    end
    else if (ce)
    begin
      // Priority: timeout, recovery causes, TS2 result
      next_state_stb_reg <= 1'b0;
      if (ts_timeout)
      begin
        next_state_reg <= ts_target;
        next_state_stb_reg <= 1'b1;
        last_ts_state_reg <= ts_target;
      end
      else if (bh_recov || hp_seq_mismatch || delay_done)
      begin
        next_state_reg <= `LS_RECOVERY;
        next_state_stb_reg <= 1'b1;
      end
      else if (ts2_valid)
      begin
        next_state_reg <= ts2_win;
        next_state_stb_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      send_lbad_reg <= 1'b0;
      lcmd_drop_reg <= 1'b0;
      payload_drop_reg <= 1'b0;
      hp_retry_reg <= 1'b0;
      disparity_err_reg <= 1'b0;
      decode_err_reg <= 1'b0;
      bh_report_reg <= 1'b0;
    end
    else if (ce)
    begin
      disparity_err_reg <= disp_bad;
      decode_err_reg <= dec_bad;
      bh_report_reg <= bh_soft || bh_recov;
      send_lbad_reg <= sym_react && sym_err && rx_in_header;
      // Unexpected commands are simply dropped
      lcmd_drop_reg <= (sym_react && sym_err && rx_in_lcmd) || lc_unexpected;
      payload_drop_reg <= sym_react && sym_err && rx_in_payload;
      hp_retry_reg <= hp_crc_bad;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (ce)
    begin
      if (reg_rd)
      begin
        case (reg_addr)
          `ADDR_CTRL: reg_rdata <= ctrl_reg;
          `ADDR_STATUS: reg_rdata <= {9'h000, delay_busy_reg, last_ts_state_reg,
                                      run_disp_reg, tally_reg[0]};
          `ADDR_LINK_ERR: reg_rdata <= link_err_cnt[15:0];
          `ADDR_SOFT_ERR: reg_rdata <= soft_err_cnt[15:0];
          `ADDR_TALLY: reg_rdata <= {14'h0000, tally_reg};
          default: reg_rdata <= 16'h0000;
        endcase
      end
      else
        reg_rdata <= 16'h0000;
    end
  end
endmodule

`default_nettype wire

//--- hw/link_err_map.vh
`ifndef LINK_ERR_MAP_VH
`define LINK_ERR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_LINK_ERR 4'h2
`define ADDR_SOFT_ERR 4'h3
`define ADDR_TALLY 4'h4

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_ENH_RATE 0
`define CTRL_DOWNSTREAM 1
`define CTRL_HUB 2
`define CTRL_DUAL_LANE 3
`define CTRL_ASSOC 4
`define CTRL_SYM_REACT 5
`define CTRL_RESET 16'h0000

// ----------------------------------------
// Link state codes
// ----------------------------------------
`define LS_NONE 3'h0
`define LS_RX_DETECT 3'h1
`define LS_INACTIVE 3'h2
`define LS_DISABLED 3'h3
`define LS_PORT_MATCH 3'h4
`define LS_RECOVERY 3'h5
`define LS_HOT_RESET 3'h6
`define LS_LOOPBACK 3'h7

// ----------------------------------------
// Timing and limits
// ----------------------------------------
`define POLL_TALLY_LIMIT 2'h2
`define DELAY_RECOV_NS 32
`define CLK_PERIOD_NS 8
`define DELAY_RECOV_CYC ((`DELAY_RECOV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hw/err_counter.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Saturating event counter
// ----------------------------------------
module err_counter #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire clear,
  input wire inc,
  output reg [WIDTH-1:0] count_reg
);
  wire sat = &count_reg;

  always @(posedge clk)
  begin
    if (!rstn)
      count_reg <= {WIDTH{1'b0}};
    else if (ce)
    begin
      // A clear and an increment in the same cycle leave the count at one
      if (inc && (!sat || clear))
        count_reg <= clear ? {{(WIDTH-1){1'b0}}, 1'b1} : count_reg + 1'b1;
      else if (clear)
        count_reg <= {WIDTH{1'b0}};
    end
  end
endmodule

`default_nettype wire

//--- testbench/link_err_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "link_err_map.vh"

// ----------------------------------------
// Port-level checks
// ----------------------------------------
module link_err_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic ts_timeout,
  input wire logic ts_in_polling,
  input wire logic ts_hot_reset_attempt,
  input wire logic sym_valid,
  input wire logic [1:0] sym_disparity,
  input wire logic sym_known,
  input wire logic rx_in_header,
  input wire logic bh_valid,
  input wire logic bh0_two_bit,
  input wire logic hp_framing_missing,
  input wire logic hp_crc_bad,
  input wire logic [2:0] next_state_reg,
  input wire logic next_state_stb_reg,
  input wire logic send_lbad_reg,
  input wire logic hp_retry_reg,
  input wire logic disparity_err_reg,
  input wire logic decode_err_reg
);
  logic [5:0] c;
  logic [2:0] fb;
  // Shadow of the framing-loss wait; losses inside it do not re-arm
  always @(posedge clk)
  begin
    if (!rstn)
      fb <= 3'h0;
    else if (ce && fb != 3'h0)
      fb <= fb - 3'h1;
    else if (ce && hp_framing_missing)
      fb <= 3'h4;
  end
  // Control shadow; timeouts beside a write are skipped since the shadow moves
  wire tmo = ce && ts_timeout && !reg_wr;
  always @(posedge clk)
  begin
    if (!rstn)
      c <= 6'h00;
    else if (ce && reg_wr && reg_addr == `ADDR_CTRL)
      c <= reg_wdata[5:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_enh_poll;
    tmo && ts_in_polling && c[0] |=> next_state_stb_reg && next_state_reg == `LS_PORT_MATCH;
  endproperty
  a_enh_poll: assert property (p_enh_poll) else $error("port match missed");
  property p_up_poll;
    tmo && ts_in_polling && c[1:0] == 2'b00
      |=> next_state_reg == (c[2] ? `LS_RX_DETECT : `LS_DISABLED);
  endproperty
  a_up_poll: assert property (p_up_poll) else $error("upstream poll target");
  property p_dn_rec;
    tmo && !ts_in_polling && c[1:0] == 2'b10
      |=> next_state_reg == ($past(ts_hot_reset_attempt) ? `LS_RX_DETECT : `LS_INACTIVE);
  endproperty
  a_dn_rec: assert property (p_dn_rec) else $error("downstream recovery target");
  property p_up_rec;
    tmo && !ts_in_polling && !c[1] |=> next_state_reg == `LS_INACTIVE;
  endproperty
  a_up_rec: assert property (p_up_rec) else $error("upstream recovery target");
  property p_sym;
    ce && sym_valid |=> disparity_err_reg == ($past(sym_disparity) == 2'b10)
      && decode_err_reg == !$past(sym_known);
  endproperty
  a_sym: assert property (p_sym) else $error("symbol flags");
  property p_lbad;
    ce && sym_valid && !sym_known && rx_in_header && c[5] |=> send_lbad_reg;
  endproperty
  a_lbad: assert property (p_lbad) else $error("no lbad");
  property p_two_bit;
    ce && bh_valid && !c[3] && bh0_two_bit && !ts_timeout
      |=> next_state_stb_reg && next_state_reg == `LS_RECOVERY;
  endproperty
  a_two_bit: assert property (p_two_bit) else $error("no recovery");
  property p_frame;
    (ce && hp_framing_missing && fb == 3'h0) ##1 ce [*3] ##1 (ce && !ts_timeout)
      |=> next_state_stb_reg && next_state_reg == `LS_RECOVERY;
  endproperty
  a_frame: assert property (p_frame) else $error("late recovery missing");
  property p_retry;
    ce && hp_crc_bad |=> hp_retry_reg;
  endproperty
  a_retry: assert property (p_retry) else $error("no retry");
  c_poll: cover property (tmo && ts_in_polling);
  c_frame: cover property (ce && hp_framing_missing);
  c_two_bit: cover property (ce && bh_valid && bh0_two_bit);
endmodule

bind link_error_recovery_handler link_err_checker chk_u (.*);
`default_nettype wire

//--- testbench/link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Far-end link layer stand-in
// ----------------------------------------
module link_partner_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] cmd,
  input wire logic [2:0] req,
  output logic [3:0] hp_ev,
  output logic ts2_valid,
  output logic [2:0] ts2_req
);
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      hp_ev <= 4'h0;
      ts2_valid <= 1'b0;
      ts2_req <= 3'h0;
    end
    else
    begin
      hp_ev <= cmd[3:0];
      ts2_valid <= cmd[4];
      // Outside a frame the request field scrambles, never holds
      ts2_req <= cmd[4] ? req : ~ts2_req;
    end
  end
endmodule
`default_nettype wire

//--- testbench/link_error_recovery_handler_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "link_err_map.vh"

// ----------------------------------------
// Table-driven bench
// ----------------------------------------
module link_error_recovery_handler_tb_top;
  localparam logic [23:0] Q = 24'h00_011c;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, elk = 16'h0000, esf = 16'h0000;
  logic ts_timeout, ts_in_polling, ts_hot_reset_attempt, ts2_valid;
  logic [2:0] ts2_local_req, ts2_partner_req, next_state_reg;
  logic sym_valid, sym_known, rx_in_header, rx_in_lcmd, rx_in_payload;
  logic [1:0] sym_disparity;
  logic bh_valid, bh0_ok, bh1_ok, bh0_corr, bh1_corr, bh0_two_bit, bh_match;
  logic hp_framing_missing, hp_crc_bad, hp_seq_mismatch, lc_unexpected;
  logic next_state_stb_reg, send_lbad_reg, lcmd_drop_reg, payload_drop_reg;
  logic hp_retry_reg, disparity_err_reg, decode_err_reg, bh_report_reg;
  logic [23:0] lv = Q;
  logic [7:0] pv = 8'h00;
  wire [3:0] hp_ev;
  int n_errors = 0;
  int checks = 0;
  // State code holds between strobes, so it is compared in every row
  wire [11:0] ov = {next_state_stb_reg, next_state_reg, bh_report_reg, send_lbad_reg,
    lcmd_drop_reg, payload_drop_reg, hp_retry_reg, disparity_err_reg, decode_err_reg, 1'b0};
  assign {ts2_local_req, ts_in_polling, ts_hot_reset_attempt, rx_in_header, rx_in_lcmd,
    rx_in_payload, sym_known, sym_disparity, bh0_two_bit, bh_match, bh0_ok, bh1_ok, bh0_corr,
    bh1_corr} = {lv[22:20], lv[15:14], lv[11:0]};
  assign {bh_valid, sym_valid, ts_timeout} = pv[2:0];
  assign {lc_unexpected, hp_seq_mismatch, hp_crc_bad, hp_framing_missing} = hp_ev;
  link_error_recovery_handler dut_u (.*);
  link_partner_model far_u (.clk(clk), .rstn(rstn), .cmd(pv[7:3]), .req(lv[18:16]),
    .hp_ev(hp_ev), .ts2_valid(ts2_valid), .ts2_req(ts2_partner_req));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task finish_test();
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Partner events reach the design one edge later than PHY ones
  task row(input logic [5:0] c, input logic [23:0] l, input logic [7:0] p,
    input logic [11:0] e, input int dl, input int ds);
    wr(`ADDR_CTRL, {10'h000, c});
    @(posedge clk);
    lv <= l;
    pv <= p;
    @(posedge clk);
    pv <= 8'h00;
    if (p[7:3] != 5'h00)
      @(posedge clk);
    #1 chk({4'h0, ov}, {4'h0, e});
    elk += 16'(dl);
    esf += 16'(ds);
    rd(`ADDR_LINK_ERR, elk);
    rd(`ADDR_SOFT_ERR, esf);
  endtask
  // A few hundred cycles of traffic; the limit leaves ample margin
  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(`ADDR_TALLY, 16'h0000);
    rd(4'hf, 16'h0000);
    row(6'h01, 24'h00_811c, 8'h01, 12'hc00, 0, 0);
    row(6'h02, 24'h00_811c, 8'h01, 12'h900, 0, 0);
    row(6'h02, 24'h00_811c, 8'h01, 12'h900, 0, 0);
    row(6'h02, 24'h00_811c, 8'h01, 12'ha00, 0, 0);
    rd(`ADDR_TALLY, 16'h0002);
    wr(`ADDR_TALLY, 16'h0000);
    rd(`ADDR_TALLY, 16'h0000);
    row(6'h04, 24'h00_811c, 8'h01, 12'h900, 0, 0);
    row(6'h00, 24'h00_811c, 8'h01, 12'hb00, 0, 0);
    row(6'h02, Q, 8'h01, 12'ha00, 0, 0);
    row(6'h02, 24'h00_411c, 8'h01, 12'h900, 0, 0);
    row(6'h00, Q, 8'h01, 12'ha00, 0, 0);
    row(6'h00, 24'h00_019c, 8'h02, 12'h204, 0, 0);
    row(6'h00, 24'h00_001c, 8'h02, 12'h202, 0, 0);
    row(6'h00, 24'h00_015c, 8'h02, 12'h200, 0, 0);
    rd(`ADDR_STATUS, 16'h0012);
    row(6'h20, 24'h00_081c, 8'h02, 12'h242, 0, 0);
    row(6'h20, 24'h00_041c, 8'h02, 12'h222, 0, 0);
    row(6'h20, 24'h00_021c, 8'h02, 12'h212, 0, 0);
    row(6'h00, 24'h00_081c, 8'h02, 12'h202, 0, 0);
    row(6'h00, 24'h00_011e, 8'h04, 12'h280, 0, 1);
    row(6'h00, 24'h00_0134, 8'h04, 12'hd80, 1, 0);
    row(6'h08, 24'h00_011e, 8'h04, 12'h580, 0, 1);
    row(6'h18, 24'h00_010a, 8'h04, 12'h580, 0, 1);
    row(6'h08, 24'h00_0100, 8'h04, 12'hd80, 1, 0);
    row(6'h08, 24'h00_010c, 8'h04, 12'hd80, 1, 0);
    row(6'h08, 24'h00_0108, 8'h04, 12'hd80, 1, 0);
    row(6'h00, Q, 8'h10, 12'h508, 0, 1);
    row(6'h00, Q, 8'h20, 12'hd00, 1, 0);
    wr(`ADDR_STATUS, 16'h0000);
    elk = 16'h0000;
    esf = 16'h0000;
    row(6'h00, Q, 8'h40, 12'h520, 0, 0);
    row(6'h02, 24'h67_011c, 8'h80, 12'he00, 0, 0);
    row(6'h00, 24'h67_011c, 8'h80, 12'hf00, 0, 0);
    row(6'h00, Q, 8'h00, 12'h700, 0, 0);
    @(posedge clk);
    pv <= 8'h08;
    @(posedge clk);
    pv <= 8'h00;
    repeat (5) @(posedge clk);
    #1 chk({4'h0, ov}, 16'h0d00);
    elk += 16'h0001;
    rd(`ADDR_LINK_ERR, elk);
    rd(`ADDR_SOFT_ERR, esf);
    // Timeout and crc loss arrive while the clock enable is low
    @(posedge clk);
    ce <= 1'b0;
    pv <= 8'h11;
    @(posedge clk);
    pv <= 8'h00;
    @(posedge clk);
    ce <= 1'b1;
    #1 chk({4'h0, ov}, 16'h0500);
    rd(`ADDR_SOFT_ERR, esf);
    finish_test();
  end
endmodule
`default_nettype wire
